// ===== core/siu_defs.svh
// constant definitions for the store instruction unit
`ifndef SIU_DEFS_SVH
`define SIU_DEFS_SVH

// instruction fields, bit 31 is the msb of the word
`define SIU_OP_HI      31
`define SIU_OP_LO      26
`define SIU_SRC_HI     25
`define SIU_SRC_LO     21
`define SIU_BASE_HI    20
`define SIU_BASE_LO    16
`define SIU_IDX_HI     15
`define SIU_IDX_LO     11
`define SIU_XO_HI      10
`define SIU_XO_LO      1
`define SIU_DISP_HI    15
`define SIU_DISP_LO    0

// primary opcodes
`define SIU_OP_EXT     6'h1f
`define SIU_OP_STFS    6'h34
`define SIU_OP_STFSU   6'h35
`define SIU_OP_STFD    6'h36
`define SIU_OP_STFDU   6'h37
`define SIU_OP_STH     6'h2c
`define SIU_OP_STHU    6'h2d

// extended opcodes under primary 31
`define SIU_XO_STBUX   10'h0f7
`define SIU_XO_STBX    10'h0d7
`define SIU_XO_STFDUX  10'h2f7
`define SIU_XO_STFDX   10'h2d7
`define SIU_XO_STFIWX  10'h3d7
`define SIU_XO_STFSUX  10'h2b7
`define SIU_XO_STFSX   10'h297
`define SIU_XO_STHBRX  10'h396

// memory access sizes in bytes
`define SIU_SZ_1       4'h1
`define SIU_SZ_2       4'h2
`define SIU_SZ_4       4'h4
`define SIU_SZ_8       4'h8

// double to single conversion
`define SIU_EXP_HI     62
`define SIU_EXP_LO     52
`define SIU_EXP_DENORM 11'h380
`define SIU_EXP_DN_ONE 11'h381
`define SIU_EXP_MIN_DN 11'h36a

`endif

// ===== core/siu_pkg.sv
// types shared by the store instruction unit
package siu_pkg;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_READ = 5'h02,
        ST_EXEC = 5'h04,
        ST_MEM  = 5'h08,
        ST_WB   = 5'h10
    } siu_state_t;

    typedef enum logic [2:0] {
        SRC_GPR_BYTE = 3'h0,
        SRC_GPR_HALF = 3'h1,
        SRC_GPR_HREV = 3'h2,
        SRC_FPR_DBL  = 3'h3,
        SRC_FPR_SGL  = 3'h4,
        SRC_FPR_INT  = 3'h5
    } siu_src_t;

endpackage

// ===== core/siu_store_unit.sv
// store instruction unit: decode, address, data and write-back
// Notes on behaviour
// - byte store update indexed: base plus index, low byte, address to base
// - byte store indexed: base or zero plus index, low byte, no update
// - update form with base field zero is invalid; flagged, nothing stored
// - double float store: base or zero plus displacement, 8 bytes
// - double float store with update: base plus displacement, update base
// - double float store update indexed: base plus index, 8 bytes, update
// - primary 31, extended 727: double float store indexed, 8 bytes
// - extended 983: low 32 float bits stored unconverted, indexed address
// - single float store: converted word at base or zero plus displacement
// - single float store with update: base plus displacement, update base
// - extended 695: single conversion, base plus index, update base
// - single float store indexed: converted word, no register update
// - half store: low 16 source bits at base or zero plus displacement
// - byte-reversed half store: low source byte lands at lower address
// - half store with update: signed displacement added, base updated
`timescale 1ns/1ps
`include "siu_defs.svh"

module siu_store_unit (
    // clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // instruction in
    input  wire logic        instr_valid,
    input  wire logic [31:0] instr,
    output logic             instr_ready_q,
    output logic             illegal_q,
    // register file read ports, data one cycle after address
    output logic [4:0]       src_gpr_q,
    output logic [4:0]       base_gpr_q,
    output logic [4:0]       index_gpr_q,
    output logic [4:0]       source_fpr_q,
    input  wire logic [31:0] src_gpr_data,
    input  wire logic [31:0] base_gpr_data,
    input  wire logic [31:0] index_gpr_data,
    input  wire logic [63:0] source_fpr_data,
    // memory write port
    output logic             mem_req_q,
    output logic [31:0]      mem_addr_q,
    output logic [3:0]       mem_size_q,
    output logic [63:0]      mem_data_q,
    input  wire logic        mem_ack,
    // base register write-back
    output logic             wb_en_q,
    output logic [4:0]       wb_gpr_q,
    output logic [31:0]      wb_data_q
);

    // ****************************************************************
    // decode of the incoming word
    // ****************************************************************
    logic             dec_ok;
    logic             dec_upd;
    logic             dec_idx;
    logic [3:0]       dec_size;
    siu_pkg::siu_src_t dec_src;
    logic [5:0]       op;
    logic [9:0]       xo;

    assign op = instr[`SIU_OP_HI:`SIU_OP_LO];
    assign xo = instr[`SIU_XO_HI:`SIU_XO_LO];

    always_comb begin
        dec_ok   = 1'b1;
        dec_upd  = 1'b0;
        dec_idx  = 1'b0;
        dec_size = `SIU_SZ_4;
        dec_src  = siu_pkg::SRC_FPR_SGL;
        case (op)
            `SIU_OP_EXT: begin
                dec_idx = 1'b1;
                case (xo)
                    `SIU_XO_STBUX: begin
                        dec_upd  = 1'b1;
                        dec_size = `SIU_SZ_1;
                        dec_src  = siu_pkg::SRC_GPR_BYTE;
                    end
                    `SIU_XO_STBX: begin
                        dec_size = `SIU_SZ_1;
                        dec_src  = siu_pkg::SRC_GPR_BYTE;
                    end
                    `SIU_XO_STFDUX: begin
                        dec_upd  = 1'b1;
                        dec_size = `SIU_SZ_8;
                        dec_src  = siu_pkg::SRC_FPR_DBL;
                    end
                    `SIU_XO_STFDX: begin
                        dec_size = `SIU_SZ_8;
                        dec_src  = siu_pkg::SRC_FPR_DBL;
                    end
                    `SIU_XO_STFIWX: begin
                        dec_src  = siu_pkg::SRC_FPR_INT;
                    end
                    `SIU_XO_STFSUX: begin
                        dec_upd  = 1'b1;
                    end
                    `SIU_XO_STFSX: begin
                        dec_upd  = 1'b0;
                    end
                    `SIU_XO_STHBRX: begin
                        dec_size = `SIU_SZ_2;
                        dec_src  = siu_pkg::SRC_GPR_HREV;
                    end
                    default: dec_ok = 1'b0;
                endcase
            end
            `SIU_OP_STFD: begin
                dec_size = `SIU_SZ_8;
                dec_src  = siu_pkg::SRC_FPR_DBL;
            end
            `SIU_OP_STFDU: begin
                dec_upd  = 1'b1;
                dec_size = `SIU_SZ_8;
                dec_src  = siu_pkg::SRC_FPR_DBL;
            end
            `SIU_OP_STFS: begin
                dec_upd  = 1'b0;
            end
            `SIU_OP_STFSU: begin
                dec_upd  = 1'b1;
            end
            `SIU_OP_STH: begin
                dec_size = `SIU_SZ_2;
                dec_src  = siu_pkg::SRC_GPR_HALF;
            end
            `SIU_OP_STHU: begin
                dec_upd  = 1'b1;
                dec_size = `SIU_SZ_2;
                dec_src  = siu_pkg::SRC_GPR_HALF;
            end
            default: dec_ok = 1'b0;
        endcase
    end

    // ****************************************************************
    // single precision conversion of the float source
    // ****************************************************************
    logic [31:0] sgl_word;
    logic [10:0] fexp;
    logic [10:0] dn_shift;
    logic [23:0] dn_frac;

    assign fexp = source_fpr_data[`SIU_EXP_HI:`SIU_EXP_LO];

    // exponents below the single normal range denormalise, below that
    // the word is forced to signed zero, except exponent zero which takes the field select; rounding is truncation here
    always_comb begin
        dn_shift = `SIU_EXP_DN_ONE - fexp;
        dn_frac  = {1'b1, source_fpr_data[51:29]} >> dn_shift;
        if (fexp > `SIU_EXP_DENORM || fexp == 11'h000) begin
            sgl_word = {source_fpr_data[63:62],
                        source_fpr_data[58:29]};
        end else if (fexp < `SIU_EXP_MIN_DN) begin
            sgl_word = {source_fpr_data[63], 31'h00000000};
        end else begin
            sgl_word = {source_fpr_data[63], 8'h00, dn_frac[22:0]};
        end
    end

    // ****************************************************************
    // sequencing state
    // ****************************************************************
    siu_pkg::siu_state_t state_q;
    siu_pkg::siu_state_t state_d;
    logic [31:0]         disp_q;
    logic [31:0]         disp_d;
    logic                upd_q;
    logic                upd_d;
    logic                idx_q;
    logic                idx_d;
    logic [3:0]          size_q;
    logic [3:0]          size_d;
    siu_pkg::siu_src_t   src_q;
    siu_pkg::siu_src_t   src_d;
    logic                ready_d;
    logic                illegal_d;
    logic [4:0]          srcg_d;
    logic [4:0]          base_d;
    logic [4:0]          index_d;
    logic [4:0]          srcf_d;
    logic                req_d;
    logic [31:0]         addr_d;
    logic [3:0]          msize_d;
    logic [63:0]         mdata_d;
    logic                wb_en_d;
    logic [4:0]          wb_gpr_d;
    logic [31:0]         wb_data_d;
    logic [31:0]         base_val;
    logic [31:0]         ea;
    logic [63:0]         data_sel;

    // base field zero reads as literal zero for non-update forms
    always_comb begin
        base_val = (base_gpr_q == 5'h00) ? 32'h00000000
                                         : base_gpr_data;
        ea = base_val + (idx_q ? index_gpr_data : disp_q);
        case (src_q)
            siu_pkg::SRC_GPR_BYTE:
                data_sel = {56'h0, src_gpr_data[7:0]};
            siu_pkg::SRC_GPR_HALF:
                data_sel = {48'h0, src_gpr_data[15:0]};
            siu_pkg::SRC_GPR_HREV:
                data_sel = {48'h0, src_gpr_data[7:0],
                            src_gpr_data[15:8]};
            siu_pkg::SRC_FPR_DBL:
                data_sel = source_fpr_data;
            siu_pkg::SRC_FPR_INT:
                data_sel = {32'h0, source_fpr_data[31:0]};
            siu_pkg::SRC_FPR_SGL:
                data_sel = {32'h0, sgl_word};
            default:
                data_sel = 64'h0;
        endcase
    end

    always_comb begin
        state_d   = state_q;
        disp_d    = disp_q;
        upd_d     = upd_q;
        idx_d     = idx_q;
        size_d    = size_q;
        src_d     = src_q;
        ready_d   = instr_ready_q;
        illegal_d = 1'b0;
        srcg_d    = src_gpr_q;
        base_d    = base_gpr_q;
        index_d   = index_gpr_q;
        srcf_d    = source_fpr_q;
        req_d     = mem_req_q;
        addr_d    = mem_addr_q;
        msize_d   = mem_size_q;
        mdata_d   = mem_data_q;
        wb_en_d   = 1'b0;
        wb_gpr_d  = wb_gpr_q;
        wb_data_d = wb_data_q;
        case (state_q)
            siu_pkg::ST_IDLE: begin
                if (instr_valid) begin
                    if (!dec_ok || (dec_upd &&
                        instr[`SIU_BASE_HI:`SIU_BASE_LO] == 5'h00)) begin
                        illegal_d = 1'b1;
                    end else begin
                        ready_d = 1'b0;
                        state_d = siu_pkg::ST_READ;
                        upd_d   = dec_upd;
                        idx_d   = dec_idx;
                        size_d  = dec_size;
                        src_d   = dec_src;
                        disp_d  = {{16{instr[`SIU_DISP_HI]}},
                            instr[`SIU_DISP_HI:`SIU_DISP_LO]};
                        srcg_d  = instr[`SIU_SRC_HI:`SIU_SRC_LO];
                        srcf_d  = instr[`SIU_SRC_HI:`SIU_SRC_LO];
                        base_d  = instr[`SIU_BASE_HI:`SIU_BASE_LO];
                        index_d = instr[`SIU_IDX_HI:`SIU_IDX_LO];
                    end
                end
            end
            siu_pkg::ST_READ: begin
                state_d = siu_pkg::ST_EXEC;
            end
            siu_pkg::ST_EXEC: begin
                req_d    = 1'b1;
                addr_d   = ea;
                msize_d  = size_q;
                mdata_d  = data_sel;
                wb_gpr_d = base_gpr_q;
                wb_data_d = ea;
                state_d  = siu_pkg::ST_MEM;
            end
            siu_pkg::ST_MEM: begin
                if (mem_ack) begin
                    req_d   = 1'b0;
                    state_d = siu_pkg::ST_WB;
                    wb_en_d = upd_q;
                end
            end
            siu_pkg::ST_WB: begin
                ready_d = 1'b1;
                state_d = siu_pkg::ST_IDLE;
            end
            default: begin
                ready_d = 1'b1;
                req_d   = 1'b0;
                state_d = siu_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q       <= siu_pkg::ST_IDLE;
            disp_q        <= 32'h00000000;
            upd_q         <= 1'b0;
            idx_q         <= 1'b0;
            size_q        <= `SIU_SZ_1;
            src_q         <= siu_pkg::SRC_GPR_BYTE;
            instr_ready_q <= 1'b1;
            illegal_q     <= 1'b0;
            src_gpr_q     <= 5'h00;
            base_gpr_q    <= 5'h00;
            index_gpr_q   <= 5'h00;
            source_fpr_q  <= 5'h00;
            mem_req_q     <= 1'b0;
            mem_addr_q    <= 32'h00000000;
            mem_size_q    <= `SIU_SZ_1;
            mem_data_q    <= 64'h0;
            wb_en_q       <= 1'b0;
            wb_gpr_q      <= 5'h00;
            wb_data_q     <= 32'h00000000;
        end else if (ce) begin
            state_q       <= state_d;
            disp_q        <= disp_d;
            upd_q         <= upd_d;
            idx_q         <= idx_d;
            size_q        <= size_d;
            src_q         <= src_d;
            instr_ready_q <= ready_d;
            illegal_q     <= illegal_d;
            src_gpr_q     <= srcg_d;
            base_gpr_q    <= base_d;
            index_gpr_q   <= index_d;
            source_fpr_q  <= srcf_d;
            mem_req_q     <= req_d;
            mem_addr_q    <= addr_d;
            mem_size_q    <= msize_d;
            mem_data_q    <= mdata_d;
            wb_en_q       <= wb_en_d;
            wb_gpr_q      <= wb_gpr_d;
            wb_data_q     <= wb_data_d;
        end
    end

endmodule

// ===== testbench/siu_store_unit_sva.sv
// assertion checker for the store instruction unit ports
`timescale 1ns/1ps

module siu_store_unit_sva (
    // clock, reset and enable
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ce,
    // instruction side
    input wire logic        instr_valid,
    input wire logic [31:0] instr,
    input wire logic        instr_ready_q,
    input wire logic        illegal_q,
    // memory and write-back
    input wire logic        mem_req_q,
    input wire logic [31:0] mem_addr_q,
    input wire logic [3:0]  mem_size_q,
    input wire logic [63:0] mem_data_q,
    input wire logic        mem_ack,
    input wire logic        wb_en_q,
    input wire logic [4:0]  wb_gpr_q,
    input wire logic [31:0] wb_data_q
);
    logic upd_form;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    assign upd_form = instr[31:26] inside {6'h35, 6'h37, 6'h2d} ||
        (instr[31:26] == 6'h1f && instr[10:1] inside
        {10'h0f7, 10'h2f7, 10'h2b7});

    sequence s_take;
        ce && instr_valid && instr_ready_q;
    endsequence
    sequence s_accept;
        mem_req_q && mem_ack;
    endsequence

    a_zero_base: assert property (
        s_take ##0 (upd_form && instr[20:16] == 5'h0)
        |=> illegal_q && instr_ready_q && !mem_req_q)
        else $error("update form with base zero not refused");
    a_legal_walk: assert property (
        s_take ##1 !illegal_q |-> !instr_ready_q[*3] ##0 mem_req_q)
        else $error("store request not on time");
    a_req_hold: assert property (
        mem_req_q && !mem_ack |=> mem_req_q && $stable(mem_addr_q) &&
        $stable(mem_size_q) && $stable(mem_data_q))
        else $error("request changed before accept");
    a_req_drop: assert property (s_accept |=> !mem_req_q)
        else $error("request held after accept");
    a_ready_back: assert property (s_accept |-> ##2 instr_ready_q)
        else $error("unit not idle after store");
    a_wb_follow: assert property (
        wb_en_q |-> $past(mem_req_q && mem_ack) && wb_gpr_q != 5'h0 &&
        wb_data_q == $past(mem_addr_q))
        else $error("write-back without store or wrong address");
    a_size_fit: assert property (
        mem_req_q |-> (mem_size_q == 4'h8) ||
        (mem_size_q == 4'h4 && mem_data_q[63:32] == 32'h0) ||
        (mem_size_q == 4'h2 && mem_data_q[63:16] == 48'h0) ||
        (mem_size_q == 4'h1 && mem_data_q[63:8] == 56'h0))
        else $error("bad size or data not right-justified");
    a_ce_freeze: assert property (
        !ce |=> $stable(instr_ready_q) && $stable(mem_req_q) &&
        $stable(mem_addr_q) && $stable(wb_en_q))
        else $error("state moved while clock enable low");
    a_ill_cause: assert property (
        illegal_q |-> $past(ce && instr_valid && instr_ready_q))
        else $error("illegal flag without a taken word");
endmodule

bind siu_store_unit siu_store_unit_sva chk (
    .clk(clk), .rst(rst), .ce(ce), .instr_valid(instr_valid),
    .instr(instr), .instr_ready_q(instr_ready_q), .illegal_q(illegal_q),
    .mem_req_q(mem_req_q), .mem_addr_q(mem_addr_q),
    .mem_size_q(mem_size_q), .mem_data_q(mem_data_q), .mem_ack(mem_ack),
    .wb_en_q(wb_en_q), .wb_gpr_q(wb_gpr_q), .wb_data_q(wb_data_q)
);

// ===== testbench/siu_mem_model.sv
// data memory write port model with prompt or stalled accept
`timescale 1ns/1ps

module siu_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic mem_req_q,
    output logic     mem_ack
);
    int wait_n;

    // accept only while request is up, so a stray ack never appears
    assign mem_ack = mem_req_q && wait_n == 0;

    always @(posedge clk or posedge rst) begin
        if (rst)
            wait_n <= 0;
        else if (mem_req_q && wait_n != 0)
            wait_n <= wait_n - 1;
        else if (!mem_req_q)
            wait_n <= slow ? $urandom_range(3, 1) : 0;
    end
endmodule

// ===== testbench/tb_siu_store_unit.sv
// self-checking bench for the store instruction unit
`timescale 1ns/1ps

module tb_siu_store_unit;
    logic clk, rst, ce, instr_valid, slow, mem_ack;
    logic [31:0] instr;
    wire logic instr_ready_q, illegal_q, mem_req_q, wb_en_q;
    wire logic [4:0] src_gpr_q, base_gpr_q, index_gpr_q, source_fpr_q;
    wire logic [4:0] wb_gpr_q;
    wire logic [31:0] mem_addr_q, wb_data_q;
    wire logic [3:0] mem_size_q;
    wire logic [63:0] mem_data_q;
    logic [31:0] gpr [32];
    logic [63:0] fpr [32];
    int n_mismatch = 0;
    int n_checks = 0;
    // last entry is an unsupported word store
    logic [31:0] tmpl [15] = '{32'h7c0001ee, 32'h7c0001ae, 32'hd8000000,
        32'hdc000000, 32'h7c0005ee, 32'h7c0005ae, 32'h7c0007ae,
        32'hd0000000, 32'hd4000000, 32'h7c00056e, 32'h7c00052e,
        32'hb0000000, 32'h7c00072c, 32'hb4000000, 32'h90000000};
    int kind [15] = '{0, 0, 3, 3, 3, 3, 5, 4, 4, 4, 4, 1, 2, 1, 0};
    logic [14:0] upd = 15'h2319;

    siu_store_unit dut (.clk(clk), .rst(rst), .ce(ce),
        .instr_valid(instr_valid), .instr(instr),
        .instr_ready_q(instr_ready_q), .illegal_q(illegal_q),
        .src_gpr_q(src_gpr_q), .base_gpr_q(base_gpr_q),
        .index_gpr_q(index_gpr_q), .source_fpr_q(source_fpr_q),
        .src_gpr_data(gpr[src_gpr_q]), .base_gpr_data(gpr[base_gpr_q]),
        .index_gpr_data(gpr[index_gpr_q]),
        .source_fpr_data(fpr[source_fpr_q]), .mem_req_q(mem_req_q),
        .mem_addr_q(mem_addr_q), .mem_size_q(mem_size_q),
        .mem_data_q(mem_data_q), .mem_ack(mem_ack), .wb_en_q(wb_en_q),
        .wb_gpr_q(wb_gpr_q), .wb_data_q(wb_data_q));
    siu_mem_model mem (.clk(clk), .rst(rst), .slow(slow),
        .mem_req_q(mem_req_q), .mem_ack(mem_ack));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // single image: normal by field select, denormal by truncating shift
    function automatic logic [31:0] sgl(logic [63:0] f);
        logic [23:0] m;
        m = {1'b1, f[51:29]} >> (11'h381 - f[62:52]);
        if (f[62:52] > 11'h380 || f[62:52] == 11'h000)
            return {f[63:62], f[58:29]};
        if (f[62:52] < 11'h36a)
            return {f[63], 31'h00000000};
        return {f[63], 8'h00, m[22:0]};
    endfunction

    // big-endian, right-justified store image of each source kind
    function automatic logic [63:0] expd(int k, logic [31:0] g,
                                         logic [63:0] f);
        case (k)
            0: return {56'h0, g[7:0]};
            1: return {48'h0, g[15:0]};
            2: return {48'h0, g[7:0], g[15:8]};
            3: return f;
            4: return {32'h0, sgl(f)};
            default: return {32'h0, f[31:0]};
        endcase
    endfunction

    task automatic run(input int i, input logic [4:0] s, input logic [4:0] a,
                       input logic [4:0] b, input logic [15:0] d);
        logic [31:0] w, ea;
        logic ix, up, ill;
        int n;
        ix = tmpl[i][31:26] == 6'h1f;
        up = upd[i];
        ill = i == 14 || (up && a == 5'h0);
        w = tmpl[i] | {6'h0, s, a, ix ? {b, 11'h0} : d};
        ea = ((a == 5'h0 && !up) ? 32'h0 : gpr[a]) +
             (ix ? gpr[b] : {{16{d[15]}}, d});
        n = 0;
        while (instr_ready_q !== 1'b1 && n < 50) begin
            @(posedge clk) #1;
            n++;
        end
        if (n == 50)
            n_mismatch++;
        instr_valid = 1'b1;
        instr = w;
        @(posedge clk) #1;
        instr_valid = 1'b0;
        instr = $urandom;
        chk(illegal_q, ill);
        if (!ill) begin
            n = 0;
            while (!(mem_req_q === 1'b1 && mem_ack === 1'b1) && n < 50) begin
                @(posedge clk) #1;
                n++;
            end
            if (n == 50)
                n_mismatch++;
            chk(mem_addr_q, ea);
            chk(mem_size_q, kind[i] == 0 ? 1 : kind[i] < 3 ? 2 :
                kind[i] == 3 ? 8 : 4);
            chk(mem_data_q, expd(kind[i], gpr[s], fpr[s]));
            chk(mem_data_q, expd(kind[i], gpr[s], fpr[s]));
            @(posedge clk) #1;
            chk(wb_en_q, up);
            if (up) begin
                chk({wb_gpr_q, wb_data_q}, {a, ea});
                chk({wb_gpr_q, wb_data_q}, {a, ea});
                gpr[a] = ea;
            end
        end
    endtask

    initial begin
        #200000;
        n_mismatch++;
        report_and_stop;
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        instr_valid = 1'b0;
        instr = 32'h0;
        slow = 1'b0;
        void'($urandom(32'hfaab45cb));
        for (int r = 0; r < 32; r++) begin
            gpr[r] = $urandom;
            fpr[r] = {1'($urandom), 11'(11'h381 + $urandom_range(252, 0)),
                      20'($urandom), 32'($urandom)};
        end
        fpr[0] = 64'h0;
        // single corners: denormal result and underflow to signed zero
        fpr[31] = 64'hb7f0000000000000;
        fpr[30] = 64'h0010000000000000;
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        chk(instr_ready_q, 1'b1);
        // base field zero: refused for update forms, zero base otherwise
        for (int i = 0; i < 15; i++)
            run(i, 5'($urandom), 5'h0, 5'($urandom), 16'($urandom));
        run(13, 5'h3, 5'h7, 5'h0, 16'h8000);
        run(11, 5'h4, 5'h9, 5'h0, 16'h7fff);
        run(7, 5'h1f, 5'h5, 5'h0, 16'h0010);
        run(10, 5'h1e, 5'h6, 5'h2, 16'h0000);
        // clock enable low: an offered word must not be taken
        repeat (2) @(posedge clk) #1;
        instr_valid = 1'b1;
        instr = tmpl[1];
        ce = 1'b0;
        repeat (3) @(posedge clk) #1;
        chk(instr_ready_q, 1'b1);
        chk(mem_req_q, 1'b0);
        instr_valid = 1'b0;
        ce = 1'b1;
        slow = 1'b1;
        for (int k = 0; k < 250; k++) begin
            if (k == 120)
                slow = 1'b0;
            run($urandom_range(14, 0), 5'($urandom), 5'($urandom),
                5'($urandom), 16'($urandom));
        end
        report_and_stop;
    end
endmodule
